// [verilog/addr_filter_pkg.sv]
// shared constants for the receive address filter table
package addr_filter_pkg;
   localparam int          ADDR_W        = 12;
   localparam int          DATA_W        = 32;
   localparam int          SLOT_COUNT    = 8;
   localparam int          SLOT_W        = 3;
   localparam int          DEST_W        = 48;
   localparam int          HIGH_W        = DEST_W - DATA_W;
   // register byte addresses
   localparam logic [11:0] FILTER_CONTROL_ADDR = 12'h708;
   localparam logic [11:0] SLOT_ENABLE_ADDR    = 12'h70C;
   localparam logic [11:0] PATTERN_BASE_ADDR   = 12'h710;
   localparam logic [11:0] PATTERN_LAST_ADDR   = 12'h74C;
   localparam logic [11:0] MASK_BASE_ADDR      = 12'h750;
   localparam logic [11:0] MASK_LAST_ADDR      = 12'h78C;
   localparam logic [11:0] HIGH_WORD_STEP      = 12'h004;
   // field positions
   localparam int          ACCEPT_ALL_BIT = 31;
   localparam int          SLOT_ENABLE_BIT = 0;
   // reset values
   localparam logic [47:0] PATTERN_RESET = 48'hFFFF_FFFF_FFFF;
   localparam logic [47:0] MASK_RESET    = 48'hFFFF_FFFF_FFFF;
   localparam logic        ACCEPT_ALL_RESET = 1'b1;
   localparam logic [2:0]  SLOT_SEL_RESET   = 3'h0;
   localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
endpackage : addr_filter_pkg

// [verilog/slot_compare.sv]
// one address table slot compare: masked equality against a destination
`timescale 1ns/10ps
module slot_compare
   import addr_filter_pkg::*;
(
   input  wire logic [47:0] destination_field,
   input  wire logic [47:0] pattern,
   input  wire logic [47:0] mask,
   input  wire logic        enable,
   output logic             pass
);
   // disabled slot lets every frame through; masked-out bits are ignored
   assign pass = !enable || // [RULE9]
                 (((destination_field ^ pattern) & mask) == '0); // [RULE6]
endmodule : slot_compare

// [verilog/rx_address_filter_table.sv]
// receive address filter table with register window and match output
//
// How it works
// RULE1: pattern registers span 0x710 to 0x74C and share one layout.
// RULE2: a pattern write lands in the selected slot, low word at 0x710.
// RULE3: the first address byte on the wire is the lowest pattern byte.
// RULE4: after reset every pattern is ones in bits 47:0, matching broadcast.
// RULE5: mask registers span 0x750 to 0x78C and reset to ones in 47:0.
// RULE6: only pattern bits whose mask bit is 1 take part in the compare.
// RULE7: software wanting a full compare sets mask bits 47:0 to one.
// RULE8: control bits 2-0 at 0x708 pick the slot the shared words reach.
// RULE9: each slot has an enable at 0x70C and passes every frame when clear.
// RULE10: control bit 31 set delivers every frame whatever its destination.
// RULE11: with the filter not built, all filter locations read as zero.
// RULE12: an enabled slot matches only if all masked bits equal its pattern.
`timescale 1ns/10ps
module rx_address_filter_table
   import addr_filter_pkg::*;
#(
   parameter bit FILTER_PRESENT = 1'b1
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [11:0] reg_addr,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   input  wire logic [47:0] destination_field,
   input  wire logic        destination_valid,
   output logic             frame_accept,
   output logic             frame_accept_valid
);
   // word codes of a two-word window
   typedef enum logic [1:0] {
      WORD_NONE = 2'h0,
      WORD_LOW  = 2'h1,
      WORD_HIGH = 2'h3
   } window_word_t;

   // table storage: one pattern and one mask per slot
   logic [DEST_W-1:0]     pattern [SLOT_COUNT];
   logic [DEST_W-1:0]     mask    [SLOT_COUNT];
   logic [SLOT_COUNT-1:0] slot_enable;
   logic [SLOT_COUNT-1:0] slot_pass;
   // control register fields
   logic [SLOT_W-1:0]     slot_sel;
   logic                  accept_all;
   // register port decode
   logic                  ctrl_hit;
   logic                  enable_hit;
   window_word_t          pat_word;
   window_word_t          msk_word;
   logic                  ctrl_write;
   logic                  enable_write;
   logic                  pat_write;
   logic                  msk_write;
   // next values of the registered outputs
   logic [DATA_W-1:0]     next_rdata;
   logic                  next_accept;

   // map an address onto a two-word window; other words of the range
   // are reserved, so they decode as no word and read zero
   function automatic window_word_t window_word(input logic [11:0] a,
                                                input logic [11:0] base,
                                                input logic [11:0] last);
      window_word_t w;
      logic [11:0]  high;
      w    = WORD_NONE;
      high = base + HIGH_WORD_STEP;
      if (a >= base && a <= last) begin
         if (a == base) begin
            w = WORD_LOW;
         end else if (a == high) begin
            w = WORD_HIGH;
         end
      end
      return w;
   endfunction : window_word

   // read view of one 48-bit table entry through its window
   function automatic logic [DATA_W-1:0] word_of(
      input logic [DEST_W-1:0] value,
      input window_word_t      word
   );
      logic [DATA_W-1:0] w;
      w = ZERO_WORD;
      if (word == WORD_LOW) begin
         w = value[DATA_W-1:0];
      end else if (word == WORD_HIGH) begin
         w[HIGH_W-1:0] = value[DEST_W-1:DATA_W];
      end
      return w;
   endfunction : word_of

   // write of one window word into a 48-bit entry; upper write bits of
   // the high word have no storage and are dropped
   function automatic logic [DEST_W-1:0] merged(
      input logic [DEST_W-1:0] old,
      input window_word_t      word,
      input logic [DATA_W-1:0] wdata
   );
      logic [DEST_W-1:0] v;
      v = old;
      if (word == WORD_LOW) begin
         v[DATA_W-1:0] = wdata;
      end else if (word == WORD_HIGH) begin
         v[DEST_W-1:DATA_W] = wdata[HIGH_W-1:0];
      end
      return v;
   endfunction : merged

   assign ctrl_hit     = (reg_addr == FILTER_CONTROL_ADDR);
   assign enable_hit   = (reg_addr == SLOT_ENABLE_ADDR);
   assign pat_word     = window_word(reg_addr, PATTERN_BASE_ADDR,
                                     PATTERN_LAST_ADDR); // [RULE1]
   assign msk_word     = window_word(reg_addr, MASK_BASE_ADDR,
                                     MASK_LAST_ADDR); // [RULE5]
   assign ctrl_write   = reg_write && ctrl_hit;
   assign enable_write = reg_write && enable_hit;
   assign pat_write    = reg_write && (pat_word != WORD_NONE);
   assign msk_write    = reg_write && (msk_word != WORD_NONE);

   // control register: slot selector and accept-everything
   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_sel   <= SLOT_SEL_RESET;
         accept_all <= ACCEPT_ALL_RESET;
      end else if (ctrl_write) begin
         slot_sel   <= reg_wdata[SLOT_W-1:0]; // [RULE8]
         accept_all <= reg_wdata[ACCEPT_ALL_BIT]; // [RULE10]
      end
   end

   // one enable per slot, reached through the selector
   always_ff @(posedge mclk) begin
      if (rst) begin
         slot_enable <= '0;
      end else if (enable_write) begin
         slot_enable[slot_sel] <= reg_wdata[SLOT_ENABLE_BIT]; // [RULE9]
      end
   end

   // pattern table; the first wire byte lives in bits 7:0, so software
   // writes the address exactly as the receive path presents it
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            pattern[i] <= PATTERN_RESET; // [RULE4]
         end
      end else if (pat_write) begin
         pattern[slot_sel] <= merged(pattern[slot_sel], pat_word,
                                     reg_wdata); // [RULE2] [RULE3]
      end
   end

   // mask table, same window layout as the patterns
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            mask[i] <= MASK_RESET; // [RULE5]
         end
      end else if (msk_write) begin
         mask[slot_sel] <= merged(mask[slot_sel], msk_word,
                                  reg_wdata); // [RULE5]
      end
   end

   // read mux; unmapped words and reserved bits read zero
   always_comb begin
      next_rdata = ZERO_WORD;
      if (ctrl_hit) begin
         next_rdata[ACCEPT_ALL_BIT] = accept_all; // [RULE10]
         next_rdata[SLOT_W-1:0]     = slot_sel; // [RULE8]
      end else if (enable_hit) begin
         next_rdata[SLOT_ENABLE_BIT] = slot_enable[slot_sel]; // [RULE9]
      end else if (pat_word != WORD_NONE) begin
         next_rdata = word_of(pattern[slot_sel], pat_word); // [RULE1]
      end else if (msk_word != WORD_NONE) begin
         next_rdata = word_of(mask[slot_sel], msk_word); // [RULE5]
      end
      if (!FILTER_PRESENT) begin
         next_rdata = ZERO_WORD; // [RULE11]
      end
   end

   // read data is registered and holds until the next read
   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= ZERO_WORD;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

   generate
      for (genvar s = 0; s < SLOT_COUNT; s++) begin : g_slot
         slot_compare u_cmp (
            .destination_field (destination_field),
            .pattern           (pattern[s]),
            .mask              (mask[s]),
            .enable            (slot_enable[s]),
            .pass              (slot_pass[s])
         );
      end
   endgenerate

   // slots combine by or, so one disabled slot opens the filter; that is
   // the literal reading of the enable and software must keep it in mind
   assign next_accept = accept_all || !FILTER_PRESENT || // [RULE10] [RULE11]
                        (|slot_pass); // [RULE12]

   // verdict pulse follows each destination by one edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         frame_accept_valid <= 1'b0;
      end else begin
         frame_accept_valid <= destination_valid;
      end
   end

   // verdict holds until the next destination
   always_ff @(posedge mclk) begin
      if (rst) begin
         frame_accept <= 1'b0;
      end else if (destination_valid) begin
         frame_accept <= next_accept;
      end
   end
endmodule : rx_address_filter_table

// [test/rx_filter_assertions.sv]
// port checks for the address filter table
`timescale 1ns/10ps
module rx_filter_checker #(
   parameter bit FILTER_PRESENT = 1'b1
)(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic [47:0] destination_field,
   input wire logic        destination_valid,
   input wire logic        frame_accept,
   input wire logic        frame_accept_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence pat_wr_rd;
      reg_write && reg_addr == 12'h710 ##1
         reg_read && !reg_write && reg_addr == 12'h710;
   endsequence
   sequence open_frame;
      reg_write && reg_addr == 12'h708 && reg_wdata[31] ##1
         !reg_write && destination_valid;
   endsequence
   chk_verdict_pulse: assert property (
      destination_valid |=> frame_accept_valid) else $error("no verdict");
   chk_no_stray: assert property (
      !destination_valid |=> !frame_accept_valid) else $error("stray verdict");
   chk_rdata_holds: assert property (
      !reg_read |=> $stable(reg_rdata)) else $error("read data moved");
   chk_pattern_back: assert property (
      pat_wr_rd |=> reg_rdata == (FILTER_PRESENT ? $past(reg_wdata, 2)
                                                 : 32'h0))
      else $error("readback");
   chk_gap_zero: assert property (
      reg_read && reg_addr == 12'h718 |=> reg_rdata == 32'h0)
      else $error("gap");
   chk_enable_reserved: assert property (
      reg_read && reg_addr == 12'h70C |=> reg_rdata[31:1] == 31'h0)
      else $error("enable reserved bits");
   chk_absent_zero: assert property (
      !FILTER_PRESENT && reg_read |=> reg_rdata == 32'h0)
      else $error("absent filter read not zero");
   chk_absent_accept: assert property (
      !FILTER_PRESENT && destination_valid |=> frame_accept)
      else $error("absent filter dropped a frame");
   chk_mask_high: assert property (
      reg_read && reg_addr == 12'h754 |=> reg_rdata[31:16] == 16'h0)
      else $error("mask high bits");
   chk_ctrl_reserved: assert property (
      reg_read && reg_addr == 12'h708 |=> reg_rdata[30:3] == 28'h0)
      else $error("control reserved bits");
   chk_open_accepts: assert property (
      open_frame |=> frame_accept) else $error("accept-all ignored");
endmodule : rx_filter_checker
bind rx_address_filter_table rx_filter_checker #(
   .FILTER_PRESENT(FILTER_PRESENT)
) chk (.mclk(mclk), .rst(rst),
   .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .destination_field(destination_field),
   .destination_valid(destination_valid), .frame_accept(frame_accept),
   .frame_accept_valid(frame_accept_valid));

// [test/dest_source.sv]
// receive datapath model handing destinations to the filter
`timescale 1ns/10ps
module dest_source (
   input  wire logic        mclk,
   output logic      [47:0] destination_field,
   output logic             destination_valid
);
   initial destination_valid = 1'b0;
   initial destination_field = 48'h0;
   // w in wire order; released field inverted so stale bits never match
   task automatic send(input logic [47:0] w);
      destination_field = {<<8{w}};
      destination_valid = 1'b1;
      @(posedge mclk);
      #1;
      destination_valid = 1'b0;
      destination_field = ~destination_field;
   endtask : send
endmodule : dest_source

// [test/tb_rx_address_filter_table.sv]
// self-checking bench for the address filter table
`timescale 1ns/10ps
module tb_rx_address_filter_table;
   logic        mclk, rst, reg_write, reg_read, frame_accept, fav;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [47:0] dest;
   logic        dvalid;
   // a second copy built without the filter: reads zero, accepts all
   logic [31:0] rdata_bare;
   logic        accept_bare, fav_bare;
   int          n_fail = 0;
   int          tests_run = 0;
   rx_address_filter_table uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .destination_field(dest),
      .destination_valid(dvalid), .frame_accept(frame_accept),
      .frame_accept_valid(fav));
   dest_source src (.mclk(mclk), .destination_field(dest),
      .destination_valid(dvalid));
   rx_address_filter_table #(.FILTER_PRESENT(1'b0)) uut_bare (.mclk(mclk),
      .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(rdata_bare),
      .destination_field(dest), .destination_valid(dvalid),
      .frame_accept(accept_bare), .frame_accept_valid(fav_bare));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_frame(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_frame
   task automatic bus(input logic w, input logic [11:0] a, input int d);
      reg_write = w;
      reg_read = !w;
      reg_addr = a;
      reg_wdata = 32'(d);
      @(posedge mclk);
      #1;
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 0);
      chk(reg_rdata, e);
      chk(rdata_bare, 32'h0);
   endtask : rd
   task automatic frame(input logic [47:0] w, input logic e);
      reg_write = 1'b0;
      reg_read = 1'b0;
      src.send(w);
      chk_frame({fav, frame_accept}, {1'b1, e});
      chk_frame({fav_bare, accept_bare}, 2'b11);
      @(posedge mclk);
      #1;
   endtask : frame
   task automatic after_reset;
      rd(12'h708, 32'h8000_0000);
      rd(12'h70C, 32'h0);
      rd(12'h714, 32'h0000_FFFF);
      rd(12'h754, 32'h0000_FFFF);
      rd(12'h718, 32'h0);
      rd(12'h74C, 32'h0);
      rd(12'h78C, 32'h0);
   endtask : after_reset
   task automatic table_match;
      for (int s = 7; s >= 0; s--) begin
         bus(1'b1, 12'h708, s);
         bus(1'b1, 12'h70C, 1);
      end
      bus(1'b1, 12'h708, 3);
      bus(1'b1, 12'h710, 32'hDDCC_BBAA);
      rd(12'h710, 32'hDDCC_BBAA);
      bus(1'b1, 12'h714, 32'h0000_FFEE);
      frame(48'hAABB_CCDD_EEFF, 1'b1);
      frame(48'hFFFF_FFFF_FFFF, 1'b1);
      frame(48'hAABB_CCDD_EEFE, 1'b0);
      bus(1'b1, 12'h750, 32'h0000_00FF);
      bus(1'b1, 12'h754, 0);
      frame(48'hAA00_0000_0001, 1'b1);
      frame(48'hAB00_0000_0001, 1'b0);
      bus(1'b1, 12'h750, 32'hFFFF_FFFF);
      bus(1'b1, 12'h754, 32'h0000_FFFF);
      frame(48'hAABB_CCDD_EEFF, 1'b1);
      frame(48'hAA00_0000_0001, 1'b0);
      bus(1'b1, 12'h708, 2);
      rd(12'h710, 32'hFFFF_FFFF);
      bus(1'b1, 12'h70C, 0);
      frame(48'hAB00_0000_0001, 1'b1);
      bus(1'b1, 12'h70C, 1);
      bus(1'b1, 12'h708, 32'h8000_0002);
      frame(48'hAB00_0000_0001, 1'b1);
   endtask : table_match
   // reset in mid-run must undo what software wrote to the table
   task automatic reset_again;
      bus(1'b1, 12'h708, 3);
      bus(1'b1, 12'h750, 0);
      {rst, reg_write} = 2'b10;
      @(posedge mclk);
      #1;
      rst = 1'b0;
      after_reset();
      bus(1'b1, 12'h708, 3);
      rd(12'h710, 32'hFFFF_FFFF);
      rd(12'h750, 32'hFFFF_FFFF);
   endtask : reset_again
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      {rst, reg_write, reg_read, reg_addr, reg_wdata} = {1'b1, 46'h0};
      repeat (4) @(posedge mclk);
      #1;
      rst = 1'b0;
      after_reset();
      table_match();
      reset_again();
      give_verdict();
   end
   // run takes about seventy cycles; the limit is over twenty-eight times that
   initial begin
      #20000;
      n_fail++;
      give_verdict();
   end
endmodule : tb_rx_address_filter_table
